// ===== rtl/dec_arith.sv
`timescale 1ns/1ps
module dec_arith (
  dec_if.arith port // Operand in, difference and flags out
);
  import dec_pkg::*;

  always_comb begin
    // Borrow ripples from low byte into high byte for the pair form
    port.result = port.operand - WORD_ONE;
    port.zf     = port.word ? (port.result == WORD_ZERO)
                            : (port.result[BYTE_W-1:0] == BYTE_ZERO);
    port.sf     = port.word ? port.result[WORD_W-1]
                            : port.result[BYTE_W-1];
    // Only the most negative value can wrap on a decrement
    port.vf     = port.word ? (port.operand == WORD_MIN_NEG)
                            : (port.operand[BYTE_W-1:0] == BYTE_MIN_NEG);
  end

endmodule : dec_arith

// ===== rtl/dec_decode.sv
`timescale 1ns/1ps
module dec_decode (
  dec_if.decode port // Opcode in, operation kind out
);
  import dec_pkg::*;

  always_comb begin
    port.valid    = 1'b0;
    port.word     = 1'b0;
    port.indirect = 1'b0;
    case (port.opcode)
      OP_DEC_R: begin
        port.valid = 1'b1;
      end
      OP_DEC_IR: begin
        port.valid    = 1'b1;
        port.indirect = 1'b1;
      end
      OP_PAIR_RR: begin
        port.valid = 1'b1;
        port.word  = 1'b1;
      end
      OP_PAIR_IR: begin
        port.valid    = 1'b1;
        port.word     = 1'b1;
        port.indirect = 1'b1;
      end
      default: begin
        port.valid = 1'b0;
      end
    endcase
  end

endmodule : dec_decode

// ===== rtl/dec_if.sv
`timescale 1ns/1ps
interface dec_if;
  import dec_pkg::*;
  logic [BYTE_W-1:0] opcode;
  logic              valid;
  logic              word;
  logic              indirect;
  logic [WORD_W-1:0] operand;
  logic [WORD_W-1:0] result;
  logic              zf;
  logic              sf;
  logic              vf;

  modport decode (input opcode, output valid, word, indirect);
  modport arith  (input operand, word, output result, zf, sf, vf);
  modport core   (output opcode, operand, input valid, word, indirect, result, zf, sf, vf);
endinterface : dec_if

// ===== rtl/dec_pkg.sv
package dec_pkg;

  // ************************************************************
  // Bus and storage geometry
  // ************************************************************
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int RF_DEPTH   = 16;
  localparam int RF_IDX_W   = 4;
  localparam int RF_IDX_LSB = 2;
  localparam int BYTE_W     = 8;
  localparam int WORD_W     = 16;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RF_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_RF_LAST = 8'h7C;
  localparam logic [1:0]        ALIGN_MASK  = 2'h0;

  // ************************************************************
  // Fields
  // ************************************************************
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_DST_LSB = 8;
  localparam int FLAG_C      = 7;
  localparam int FLAG_Z      = 6;
  localparam int FLAG_S      = 5;
  localparam int FLAG_V      = 4;
  localparam int FLAG_D      = 3;
  localparam int FLAG_H      = 2;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_BADOP  = 1;
  localparam int STAT_PAD_W  = DATA_W - 2;
  localparam int BYTE_PAD_W  = DATA_W - BYTE_W;

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [BYTE_W-1:0]   FLAGS_RST    = 8'h00;
  localparam logic [BYTE_W-1:0]   RF_RST       = 8'h00;
  localparam logic [DATA_W-1:0]   RDATA_RST    = 32'h0000_0000;
  localparam logic [BYTE_W-1:0]   BYTE_ZERO    = 8'h00;
  localparam logic [WORD_W-1:0]   WORD_ONE     = 16'h0001;
  localparam logic [WORD_W-1:0]   WORD_ZERO    = 16'h0000;
  localparam logic [WORD_W-1:0]   WORD_MIN_NEG = 16'h8000;
  localparam logic [BYTE_W-1:0]   BYTE_MIN_NEG = 8'h80;
  localparam logic [BYTE_W-1:0]   BYTE_ONE     = 8'h01;
  localparam logic [RF_IDX_W-1:0] IDX_ONE      = 4'h1;
  localparam logic [RF_IDX_W-1:0] CNT_ZERO     = 4'h0;

  // ************************************************************
  // Opcodes and execution times
  // ************************************************************
  localparam logic [BYTE_W-1:0]   OP_DEC_R     = 8'h00;
  localparam logic [BYTE_W-1:0]   OP_DEC_IR    = 8'h01;
  localparam logic [BYTE_W-1:0]   OP_PAIR_RR   = 8'h80;
  localparam logic [BYTE_W-1:0]   OP_PAIR_IR   = 8'h81;
  localparam logic [RF_IDX_W-1:0] CYC_BYTE     = 4'h4;
  localparam logic [RF_IDX_W-1:0] CYC_WORD     = 4'h8;

  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_e;

endpackage : dec_pkg

// ===== rtl/dec_unit.sv
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// ************************************************************
// Operation
// - Byte decrement reads the 8-bit destination, subtracts one and writes it back there.
// - Pair decrement joins destination and next register into 16 bits, subtracts one, writes both.
// - Zero flag is set when the whole result, all 16 bits for the pair form, is zero.
// - Sign flag follows the most significant bit of the result.
// - Overflow flag is set when the most negative value wrapped to the most positive.
// ************************************************************
module dec_unit (
  input  wire logic                       CLK_I,            // Core clock, 125 MHz
  input  wire logic                       ARST_N_I,         // Async reset, active low
  input  wire logic [dec_pkg::ADDR_W-1:0] AVS_ADDRESS_I,    // Byte address
  input  wire logic                       AVS_READ_I,       // Read request
  input  wire logic                       AVS_WRITE_I,      // Write request
  input  wire logic [dec_pkg::DATA_W-1:0] AVS_WRITEDATA_I,  // Write data
  input  wire logic [3:0]                 AVS_BYTEENABLE_I, // Lane 0 enables every write; the CMD destination field sits in lane 1
  output logic      [dec_pkg::DATA_W-1:0] AVS_READDATA_O,   // Registered read data
  output logic                            AVS_WAITREQUEST_O // Stall
);
  import dec_pkg::*;

  // ************************************************************
  // Submodules
  // ************************************************************
  dec_if u_if ();

  dec_decode u_decode (
    .port (u_if)
  );

  dec_arith u_arith (
    .port (u_if)
  );

  // ************************************************************
  // State
  // ************************************************************
  logic                ack;
  logic                next_ack;
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   next_rdata;
  exec_state_e         state;
  exec_state_e         next_state;
  logic [RF_IDX_W-1:0] cnt;
  logic [RF_IDX_W-1:0] next_cnt;
  logic [RF_IDX_W-1:0] ea;
  logic [RF_IDX_W-1:0] next_ea;
  logic [BYTE_W-1:0]   op_q;
  logic [BYTE_W-1:0]   next_op;
  logic                badop;
  logic                next_badop;
  logic [BYTE_W-1:0]   rf         [RF_DEPTH];
  logic [BYTE_W-1:0]   next_rf    [RF_DEPTH];
  logic [BYTE_W-1:0]   flags;
  logic [BYTE_W-1:0]   next_flags;

  logic                req;
  logic                busy;
  logic                acc_wr;
  logic [ADDR_W-1:0]   word_addr;
  logic                hit_cmd;
  logic                hit_flags;
  logic                hit_status;
  logic                hit_rf;
  logic [RF_IDX_W-1:0] rf_idx;
  logic [RF_IDX_W-1:0] cmd_dst;
  logic                cmd_wr;
  logic                wb_en;
  logic [RF_IDX_W-1:0] ea_p1;

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign req        = AVS_READ_I | AVS_WRITE_I;
  assign busy       = (state != ST_IDLE);
  assign word_addr  = {AVS_ADDRESS_I[ADDR_W-1:RF_IDX_LSB], ALIGN_MASK};
  assign hit_cmd    = (word_addr == OFS_CMD);
  assign hit_flags  = (word_addr == OFS_FLAGS);
  assign hit_status = (word_addr == OFS_STATUS);
  assign hit_rf     = (word_addr >= OFS_RF_BASE) && (word_addr <= OFS_RF_LAST);
  assign rf_idx     = AVS_ADDRESS_I[RF_IDX_LSB +: RF_IDX_W];
  assign cmd_dst    = AVS_WRITEDATA_I[CMD_DST_LSB +: RF_IDX_W];
  // Every access waits at least one cycle so read data comes from a flop
  assign AVS_WAITREQUEST_O = req & ~ack;
  assign AVS_READDATA_O    = rdata;
  assign acc_wr     = ack & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  assign cmd_wr     = acc_wr & hit_cmd;

  always_comb begin
    // Writes stall while an instruction runs; reads take only the one wait cycle
    next_ack   = req & ~ack & ~(AVS_WRITE_I & busy);
    next_rdata = rdata;
    if (req & ~ack) begin
      if (hit_flags) begin
        next_rdata = {{BYTE_PAD_W{1'b0}}, flags};
      end else if (hit_status) begin
        next_rdata = {{STAT_PAD_W{1'b0}}, badop, busy};
      end else if (hit_rf) begin
        next_rdata = {{BYTE_PAD_W{1'b0}}, rf[rf_idx]};
      end else begin
        next_rdata = RDATA_RST;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack   <= 1'b0;
      rdata <= RDATA_RST;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Execution sequencer
  // ************************************************************
  // Latched opcode drives decode while running, bus data while idle
  assign u_if.opcode  = busy ? op_q : AVS_WRITEDATA_I[CMD_OP_LSB +: BYTE_W];
  assign ea_p1        = ea + IDX_ONE;
  // Pair: destination holds the high byte, the next index the low byte
  assign u_if.operand = u_if.word ? {rf[ea], rf[ea_p1]} : {BYTE_ZERO, rf[ea]};
  assign wb_en        = (state == ST_EXEC) && (cnt == CNT_ZERO);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_ea    = ea;
    next_op    = op_q;
    next_badop = badop;
    case (state)
      ST_IDLE: begin
        if (cmd_wr) begin
          if (u_if.valid) begin
            next_op    = u_if.opcode;
            // No even check: odd index is the caller's fault, pair wraps
            next_ea    = u_if.indirect ? rf[cmd_dst][RF_IDX_W-1:0] : cmd_dst;
            next_cnt   = u_if.word ? (CYC_WORD - IDX_ONE) : (CYC_BYTE - IDX_ONE);
            next_state = ST_EXEC;
            next_badop = 1'b0;
          end else begin
            next_badop = 1'b1;
          end
        end else if (acc_wr && hit_status && AVS_WRITEDATA_I[STAT_BADOP]) begin
          next_badop = 1'b0;
        end
      end
      ST_EXEC: begin
        if (cnt == CNT_ZERO) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - IDX_ONE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= ST_IDLE;
      cnt   <= CNT_ZERO;
      ea    <= CNT_ZERO;
      op_q  <= OP_DEC_R;
      badop <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      ea    <= next_ea;
      op_q  <= next_op;
      badop <= next_badop;
    end
  end

  // ************************************************************
  // Register file and flags
  // ************************************************************
  always_comb begin
    next_rf    = rf;
    next_flags = flags;
    if (acc_wr && hit_rf) begin
      next_rf[rf_idx] = AVS_WRITEDATA_I[BYTE_W-1:0];
    end
    if (acc_wr && hit_flags) begin
      next_flags = AVS_WRITEDATA_I[BYTE_W-1:0];
    end
    // Bus writes stall while busy, so these never meet the bus ones
    if (wb_en) begin
      if (u_if.word) begin
        next_rf[ea]    = u_if.result[WORD_W-1:BYTE_W];
        next_rf[ea_p1] = u_if.result[BYTE_W-1:0];
      end else begin
        next_rf[ea]    = u_if.result[BYTE_W-1:0];
      end
      // Carry, decimal and half-carry bits are left as they are
      next_flags[FLAG_Z] = u_if.zf;
      next_flags[FLAG_S] = u_if.sf;
      next_flags[FLAG_V] = u_if.vf;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < RF_DEPTH; i++) begin
        rf[i] <= RF_RST;
      end
      flags <= FLAGS_RST;
    end else begin
      rf    <= next_rf;
      flags <= next_flags;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  logic start_byte;
  logic start_word;
  assign start_byte = cmd_wr && !busy && u_if.valid && !u_if.word;
  assign start_word = cmd_wr && !busy && u_if.valid && u_if.word;

  chk_byte_wb: assert property (
    wb_en && !u_if.word |=> rf[$past(ea)] == ($past(u_if.operand[BYTE_W-1:0]) - BYTE_ONE))
    else $error("byte decrement wrote a wrong value");

  chk_pair_wb: assert property (
    wb_en && u_if.word |=>
      {rf[$past(ea)], rf[$past(ea_p1)]} == ($past(u_if.operand) - WORD_ONE))
    else $error("pair decrement wrote a wrong value");

  chk_zero_flag: assert property (
    wb_en |=> flags[FLAG_Z] == ($past(u_if.word) ? ($past(u_if.operand) == WORD_ONE)
                                 : ($past(u_if.operand[BYTE_W-1:0]) == BYTE_ONE)))
    else $error("zero flag does not match result");

  chk_sign_flag: assert property (
    wb_en |=> flags[FLAG_S] == rf[$past(ea)][BYTE_W-1])
    else $error("sign flag does not match result msb");

  chk_ovf_flag: assert property (
    wb_en |=> flags[FLAG_V] == ($past(u_if.word) ? ($past(u_if.operand) == WORD_MIN_NEG)
                                 : ($past(u_if.operand[BYTE_W-1:0]) == BYTE_MIN_NEG)))
    else $error("overflow flag wrong");

  chk_kept_flags: assert property (
    wb_en |=> $stable(flags[FLAG_C]) && $stable(flags[FLAG_D]) && $stable(flags[FLAG_H]))
    else $error("carry, decimal or half flag changed");

  chk_byte_time: assert property (
    start_byte |=> busy [*4] ##1 !busy)
    else $error("byte form did not take four cycles");

  chk_pair_time: assert property (
    start_word |=> busy [*8] ##1 !busy)
    else $error("pair form did not take eight cycles");

  chk_ptr_direct: assert property (
    (start_byte || start_word) && !u_if.indirect |=> ea == $past(cmd_dst))
    else $error("direct form latched a wrong index");

  chk_ptr_indirect: assert property (
    (start_byte || start_word) && u_if.indirect |=>
      ea == $past(rf[cmd_dst][RF_IDX_W-1:0]))
    else $error("indirect form latched a wrong pointer");

  chk_bad_opcode: assert property (
    cmd_wr && !busy && !u_if.valid |=> badop && !busy)
    else $error("unknown opcode was not refused");

  chk_badop_clear: assert property (
    acc_wr && hit_status && AVS_WRITEDATA_I[STAT_BADOP] |=> !badop)
    else $error("bad opcode flag did not clear");

  chk_flags_hold: assert property (
    !wb_en && !(acc_wr && hit_flags) |=> $stable(flags))
    else $error("flags changed with no decrement or write");

  // Bus rules hold whatever instruction is running
  chk_write_stall: assert property (
    AVS_WRITE_I && busy |-> AVS_WAITREQUEST_O)
    else $error("write accepted while an instruction runs");

  chk_rdata_hold: assert property (
    !(AVS_READ_I || AVS_WRITE_I) |=> $stable(AVS_READDATA_O))
    else $error("read data moved with no request");

  cov_byte_ind: cover property (start_byte && u_if.indirect);
  cov_byte_dir: cover property (start_byte && !u_if.indirect);
  cov_pair_ind: cover property (start_word && u_if.indirect);
  cov_pair_zero: cover property (wb_en && u_if.word && u_if.zf);
  cov_bad_op: cover property (cmd_wr && !u_if.valid);

endmodule : dec_unit

// ===== tb/decrement_byte_word_unit_bench.sv
`timescale 1ns/1ps
module decrement_byte_word_unit_bench;
  import dec_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] addr;
  logic              rd_en;
  logic              wr_en;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        be;
  logic [DATA_W-1:0] rdata;
  logic              waitreq;
  int                fails;
  int                cmp_count;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] qh;
  logic [DATA_W-1:0] ql;
  logic [BYTE_W-1:0] init;
  logic [BYTE_W-1:0] bres;
  logic [WORD_W-1:0] wres;
  int                n1;
  int                n2;
  int                tgt;
  logic [BYTE_W-1:0] bv [5] = '{8'h01, 8'h00, 8'h80, 8'h81, 8'h10};
  logic [WORD_W-1:0] hv [5] = '{16'h0001, 16'h0000, 16'h8000, 16'h0100, 16'h1234};

  initial clk = 1'b0;
  always #4 clk = ~clk;

  dec_unit u_dec_unit (
    .CLK_I             (clk),
    .ARST_N_I          (arst_n),
    .AVS_ADDRESS_I     (addr),
    .AVS_READ_I        (rd_en),
    .AVS_WRITE_I       (wr_en),
    .AVS_WRITEDATA_I   (wdata),
    .AVS_BYTEENABLE_I  (be),
    .AVS_READDATA_O    (rdata),
    .AVS_WAITREQUEST_O (waitreq)
  );

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_span(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] %0t cycles got %h exp %h", $time, got, exp);
    end
  endtask : chk_span

  // Waitrequest and read data are both taken at the same rising edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] b, output logic [DATA_W-1:0] r, output int n);
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0);
    r = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    int                n;
    bus(1'b1, a, d, 4'h1, r, n);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] r);
    int n;
    bus(1'b0, a, 32'h0000_0000, 4'h1, r, n);
  endtask : rd

  function automatic logic [ADDR_W-1:0] rf(input int idx);
    rf = OFS_RF_BASE + ADDR_W'(4 * idx);
  endfunction : rf

  task automatic cmd(input logic [BYTE_W-1:0] op, input int dst);
    wr(OFS_CMD, {20'h0_0000, 4'(dst), op});
  endtask : cmd

  // Polls busy; a hang here is cut by the watchdog
  task automatic run(input logic [BYTE_W-1:0] op, input int dst);
    logic [DATA_W-1:0] r;
    cmd(op, dst);
    do rd(OFS_STATUS, r); while (r[STAT_BUSY] !== 1'b0);
  endtask : run

  function automatic logic [DATA_W-1:0] flg(input logic [BYTE_W-1:0] f0,
      input logic [WORD_W-1:0] res, input logic [WORD_W-1:0] old, input logic word);
    logic [BYTE_W-1:0] f;
    f         = f0;
    f[FLAG_Z] = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
    f[FLAG_S] = word ? res[15] : res[7];
    f[FLAG_V] = word ? (old == 16'h8000) : (old[7:0] == 8'h80);
    flg       = {24'h00_0000, f};
  endfunction : flg

  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    addr   = 8'h00;
    rd_en  = 1'b0;
    wr_en  = 1'b0;
    wdata  = 32'h0000_0000;
    be     = 4'h1;
    fails  = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_FLAGS, q);
    chk_val(q, {24'h00_0000, FLAGS_RST});
    rd(OFS_STATUS, q);
    chk_val(q, 32'h0000_0000);
    rd(rf(5), q);
    chk_val(q, {24'h00_0000, RF_RST});
    rd(8'h20, q);
    chk_val(q, 32'h0000_0000);
    // Direct and indirect forms on a small worked case
    wr(rf(1), 32'h0000_0003);
    wr(rf(3), 32'h0000_0010);
    run(OP_DEC_IR, 1);
    rd(rf(3), q);
    chk_val(q, 32'h0000_000F);
    run(OP_DEC_R, 1);
    rd(rf(1), q);
    chk_val(q, 32'h0000_0002);
    // Byte boundaries, flags preset alternately all-set and Z/S/V-clear
    for (int i = 0; i < 5; i++) begin
      init = i[0] ? 8'hFC : 8'h8C;
      tgt  = i[0] ? 9 : 3;
      wr(OFS_FLAGS, {24'h00_0000, init});
      wr(rf(6), 32'h0000_0009);
      wr(rf(tgt), {24'h00_0000, bv[i]});
      run(i[0] ? OP_DEC_IR : OP_DEC_R, i[0] ? 6 : 3);
      bres = bv[i] - BYTE_ONE;
      rd(rf(tgt), q);
      chk_val(q, {24'h00_0000, bres});
      rd(OFS_FLAGS, q);
      chk_val(q, flg(init, {8'h00, bres}, {8'h00, bv[i]}, 1'b0));
    end
    // Pair boundaries, even first index only
    for (int i = 0; i < 5; i++) begin
      init = i[0] ? 8'h8C : 8'hFC;
      tgt  = i[0] ? 10 : 2;
      wr(OFS_FLAGS, {24'h00_0000, init});
      wr(rf(4), 32'h0000_000A);
      wr(rf(tgt), {24'h00_0000, hv[i][15:8]});
      wr(rf(tgt + 1), {24'h00_0000, hv[i][7:0]});
      run(i[0] ? OP_PAIR_IR : OP_PAIR_RR, i[0] ? 4 : 2);
      wres = hv[i] - WORD_ONE;
      rd(rf(tgt), qh);
      chk_val(qh, {24'h00_0000, wres[15:8]});
      rd(rf(tgt + 1), ql);
      chk_val(ql, {24'h00_0000, wres[7:0]});
      rd(OFS_FLAGS, q);
      chk_val(q, flg(init, wres, hv[i], 1'b1));
      chk_val({31'h0000_0000, (qh[7:0] | ql[7:0]) == 8'h00}, {31'h0000_0000, q[FLAG_Z]});
    end
    // Unknown opcode leaves the file alone and flags itself
    wr(rf(3), 32'h0000_0055);
    cmd(8'h02, 3);
    rd(OFS_STATUS, q);
    chk_val(q, 32'h0000_0002);
    rd(rf(3), q);
    chk_val(q, 32'h0000_0055);
    wr(OFS_STATUS, 32'h0000_0002);
    rd(OFS_STATUS, q);
    chk_val(q, 32'h0000_0000);
    // Lane 0 disabled: write ignored
    rd(OFS_FLAGS, ql);
    bus(1'b1, OFS_FLAGS, 32'h0000_00FF, 4'h0, q, n1);
    rd(OFS_FLAGS, q);
    chk_val(q, ql);
    // Pair form stalls a write issued right after it four cycles longer
    cmd(OP_DEC_R, 3);
    bus(1'b1, OFS_FLAGS, 32'h0000_0000, 4'h1, q, n1);
    cmd(OP_PAIR_RR, 2);
    bus(1'b1, OFS_FLAGS, 32'h0000_0000, 4'h1, q, n2);
    chk_span(n2 - n1, int'(CYC_WORD) - int'(CYC_BYTE));
    // Busy is visible to a read while an instruction runs
    cmd(OP_DEC_R, 3);
    rd(OFS_STATUS, q);
    chk_val(q & 32'h0000_0001, 32'h0000_0001);
    end_of_test();
  end

endmodule : decrement_byte_word_unit_bench
